// File: hdl/sgc_pkg.sv
package sgc_pkg;
    localparam int NSRC = 7;
    localparam int NPER = 33;
    // interrupt source bit positions, shared by mask and both status views
    localparam int SRC_LOCK = 0;
    localparam int SRC_CURLIM = 1;
    localparam int SRC_IOSC = 2;
    localparam int SRC_MOSC = 3;
    localparam int SRC_POR = 4;
    localparam int SRC_BOR = 5;
    localparam int SRC_LLFAIL = 6;
    // register word addresses
    localparam logic [7:0] A_INT_EN_SET = 8'h00;
    localparam logic [7:0] A_INT_EN_CLR = 8'h04;
    localparam logic [7:0] A_INT_EN = 8'h08;
    localparam logic [7:0] A_INT_RAW = 8'h0C;
    localparam logic [7:0] A_INT_MSK = 8'h10;
    localparam logic [7:0] A_INT_CLR = 8'h14;
    localparam logic [7:0] A_REG_LVL = 8'h18;
    localparam logic [7:0] A_GATE_SW = 8'h1C;
    localparam logic [7:0] A_RUN_EN = 8'h20;
    localparam logic [7:0] A_RUN_EN_HI = 8'h24;
    localparam logic [7:0] A_SLP_EN = 8'h28;
    localparam logic [7:0] A_SLP_EN_HI = 8'h2C;
    localparam logic [7:0] A_DSLP_EN = 8'h30;
    localparam logic [7:0] A_DSLP_EN_HI = 8'h34;
    // regulator level codes: 0 = 2.25 V ... 10 = 2.75 V in 50 mV steps
    localparam int LVL_W = 4;
    localparam logic [3:0] LVL_MAX = 4'hA;
    localparam logic [3:0] LVL_RESET = 4'h5;
    localparam logic [32:0] RUN_RESET = 33'h0;
    localparam logic [32:0] SLP_RESET = 33'h1FFFFFFFF;
    localparam logic [32:0] DSLP_RESET = 33'h1FFFFFFFF;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sgc_req_t;
    typedef struct packed {
        logic sleep;
        logic deep_sleep;
    } sgc_cpu_t;
endpackage : sgc_pkg

// File: hdl/sgc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sgc_sync
(
    // clock
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // pin in, qualified level out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sgc_sync_st_t;
    sgc_sync_st_t st_r, st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // second and third must agree before a change is taken
        if (st_r.s2 == st_r.s3)
            st_nxt.q = st_r.s3;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end
    assign q = st_r.q;
endmodule : sgc_sync
`default_nettype wire

// File: hdl/sgc_gate.sv
`timescale 1ns/100ps
`default_nettype none
module sgc_gate
(
    // settings of one peripheral
    input wire logic run_en,
    input wire logic slp_en,
    input wire logic dslp_en,
    input wire logic gating_on,
    // processor state
    input wire logic sleep,
    input wire logic deep_sleep,
    // clock enable for the peripheral
    output logic clk_on
);
    always_comb
    begin
        if (!gating_on)
            clk_on = run_en;
        else if (deep_sleep)
            clk_on = run_en & dslp_en;
        else if (sleep)
            clk_on = run_en & slp_en;
        else
            clk_on = run_en;
    end
endmodule : sgc_gate
`default_nettype wire

// File: hdl/sgc_top.sv
// What this block does
// - seven system interrupt sources, one bit each
// - enable write sets only selected bits
// - disable write clears only selected bits
// - only enabled sources drive interrupt line
// - raw and masked status views readable
// - status views share mask bit positions
// - regulator resets 2.5 V, plus/minus ten percent
// - eleven levels, 2.25 to 2.75 V
// - regulator readback returns held level
// - switch clear: sleeps clock as run
// - switch set: sleep/deep-sleep enable bits apply
// - deep-sleep disabled peripheral stops in deep-sleep
// - exit restores clocks, state kept
// - deep-sleep bits kept, ignored while switch clear
// - thirty-three peripheral gating bits
// - clear write drops selected pending bits
// - run enables cleared at power-up
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sgc_top
    import sgc_pkg::*;
#(
    parameter int NS = 7,
    parameter int NP = 33
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire sgc_pkg::sgc_req_t req,
    output logic [31:0] rdata,
    // interrupt source pulses or levels from the analog side
    input wire logic [6:0] src_event,
    // processor state indications
    input wire sgc_pkg::sgc_cpu_t cpu,
    // outputs
    output logic irq,
    output logic [3:0] onchip_regulator,
    output logic [32:0] periph_clk_en,
    output logic [32:0] periph_run_en
);
    import sgc_pkg::*;
    typedef struct packed {
        logic [6:0] int_en;
        logic [6:0] pend;
        logic [3:0] lvl;
        logic gate_sw;
        logic [32:0] run_en;
        logic [32:0] slp_en;
        logic [32:0] dslp_en;
        logic [32:0] clk_en;
        logic irq;
        logic [31:0] rdata;
    } sgc_st_t;
    sgc_st_t st_r, st_nxt;
    logic [6:0] src_q;
    logic [32:0] clk_on;
    logic sleep_q;
    logic dsleep_q;
    // sources arrive from other domains, so each is qualified
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_src
            sgc_sync u_sync
            (
                .clk(clk),
                .reset(reset),
                .ce(ce),
                .d(src_event[gi]),
                .q(src_q[gi])
            );
        end
        for (gi = 0; gi < NP; gi++)
        begin : g_gate
            sgc_gate u_gate
            (
                .run_en(st_r.run_en[gi]),
                .slp_en(st_r.slp_en[gi]),
                .dslp_en(st_r.dslp_en[gi]),
                .gating_on(st_r.gate_sw),
                .sleep(sleep_q),
                .deep_sleep(dsleep_q),
                .clk_on(clk_on[gi])
            );
        end
    endgenerate
    // processor state is on this clock, used directly
    assign sleep_q = cpu.sleep;
    assign dsleep_q = cpu.deep_sleep;
    logic [6:0] src_prev_r;
    logic [6:0] src_rise;
    always_ff @(posedge clk)
    begin
        if (reset)
            src_prev_r <= '0;
        else if (ce)
            src_prev_r <= src_q;
    end
    assign src_rise = src_q & ~src_prev_r;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = '0;
        if (req.wr)
        begin
            case (req.addr)
                A_INT_EN_SET: st_nxt.int_en = st_r.int_en | req.wdata[6:0];
                A_INT_EN_CLR: st_nxt.int_en = st_r.int_en & ~req.wdata[6:0];
                A_INT_EN: st_nxt.int_en = req.wdata[6:0];
                A_INT_CLR: st_nxt.pend = st_r.pend & ~req.wdata[6:0];
                A_REG_LVL:
                begin
                    // out-of-range codes are dropped to keep the rail in bounds
                    if (req.wdata[3:0] <= LVL_MAX)
                        st_nxt.lvl = req.wdata[3:0];
                end
                A_GATE_SW: st_nxt.gate_sw = req.wdata[0];
                A_RUN_EN: st_nxt.run_en[31:0] = req.wdata;
                A_RUN_EN_HI: st_nxt.run_en[32] = req.wdata[0];
                A_SLP_EN: st_nxt.slp_en[31:0] = req.wdata;
                A_SLP_EN_HI: st_nxt.slp_en[32] = req.wdata[0];
                A_DSLP_EN: st_nxt.dslp_en[31:0] = req.wdata;
                A_DSLP_EN_HI: st_nxt.dslp_en[32] = req.wdata[0];
                default: ;
            endcase
        end
        // a new event wins over a same-cycle clear
        st_nxt.pend = st_nxt.pend | src_rise;
        if (req.rd)
        begin
            case (req.addr)
                A_INT_EN: st_nxt.rdata = {25'h0, st_r.int_en};
                A_INT_RAW: st_nxt.rdata = {25'h0, st_r.pend};
                A_INT_MSK: st_nxt.rdata = {25'h0, st_r.pend & st_r.int_en};
                A_REG_LVL: st_nxt.rdata = {28'h0, st_r.lvl};
                A_GATE_SW: st_nxt.rdata = {31'h0, st_r.gate_sw};
                A_RUN_EN: st_nxt.rdata = st_r.run_en[31:0];
                A_RUN_EN_HI: st_nxt.rdata = {31'h0, st_r.run_en[32]};
                A_SLP_EN: st_nxt.rdata = st_r.slp_en[31:0];
                A_SLP_EN_HI: st_nxt.rdata = {31'h0, st_r.slp_en[32]};
                A_DSLP_EN: st_nxt.rdata = st_r.dslp_en[31:0];
                A_DSLP_EN_HI: st_nxt.rdata = {31'h0, st_r.dslp_en[32]};
                default: st_nxt.rdata = '0;
            endcase
        end
        st_nxt.irq = |(st_nxt.pend & st_nxt.int_en);
        st_nxt.clk_en = clk_on;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.lvl <= LVL_RESET;
            st_r.run_en <= RUN_RESET;
            st_r.slp_en <= SLP_RESET;
            st_r.dslp_en <= DSLP_RESET;
        end
        else if (ce)
            st_r <= st_nxt;
    end
    assign rdata = st_r.rdata;
    assign irq = st_r.irq;
    assign onchip_regulator = st_r.lvl;
    assign periph_clk_en = st_r.clk_en;
    assign periph_run_en = st_r.run_en;

    // interrupt mask and status
    AST_IRQ_MASK: assert property (
        @(posedge clk) disable iff (reset)
        ce && !req.wr
        |=> irq == |($past(st_nxt.pend) & st_r.int_en))
        else $error("irq not matching masked pending");
    AST_IRQ_OFF: assert property (
        @(posedge clk) disable iff (reset)
        ce && (st_nxt.pend & st_nxt.int_en) == 7'h0
        |=> !irq)
        else $error("irq raised with nothing enabled and pending");
    AST_EN_SET: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_EN_SET
        |=> st_r.int_en == ($past(st_r.int_en) | $past(req.wdata[6:0])))
        else $error("enable set wrong");
    AST_EN_CLR: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_EN_CLR
        |=> st_r.int_en == ($past(st_r.int_en) & ~$past(req.wdata[6:0])))
        else $error("enable clear wrong");
    AST_EN_KEEP: assert property (
        @(posedge clk) disable iff (reset)
        ce && !(req.wr && (req.addr == A_INT_EN_SET || req.addr == A_INT_EN_CLR || req.addr == A_INT_EN))
        |=> $stable(st_r.int_en))
        else $error("enables changed without a write");
    AST_EN_DIRECT: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_EN
        |=> st_r.int_en == $past(req.wdata[6:0]))
        else $error("direct enable write wrong");
    AST_EN_READ: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_INT_EN
        |=> rdata == {25'h0, $past(st_r.int_en)})
        else $error("enable readback wrong");
    AST_RAW_READ: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_INT_RAW
        |=> rdata == {25'h0, $past(st_r.pend)})
        else $error("raw view wrong");
    AST_MSK_READ: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_INT_MSK
        |=> rdata == {25'h0, $past(st_r.pend & st_r.int_en)})
        else $error("masked view wrong");
    AST_RDATA_IDLE: assert property (
        @(posedge clk) disable iff (reset)
        ce && !req.rd
        |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_CLR_PEND: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_CLR && src_rise == 7'h0
        |=> (st_r.pend & $past(req.wdata[6:0])) == 7'h0)
        else $error("pending not cleared");
    AST_CLR_KEEP: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_CLR
        |=> ($past(st_r.pend) & ~$past(req.wdata[6:0]) & ~st_r.pend) == 7'h0)
        else $error("unselected pending bit lost");
    AST_SET_WINS: assert property (
        @(posedge clk) disable iff (reset)
        ce && src_rise != 7'h0
        |=> (st_r.pend & $past(src_rise)) == $past(src_rise))
        else $error("new event not latched");
    AST_PEND_HOLD: assert property (
        @(posedge clk) disable iff (reset)
        ce && src_rise == 7'h0 && !(req.wr && req.addr == A_INT_CLR)
        |=> $stable(st_r.pend))
        else $error("pending changed with no event or clear");
    // regulator
    AST_LVL_RANGE: assert property (
        @(posedge clk) disable iff (reset)
        onchip_regulator <= LVL_MAX)
        else $error("regulator level out of range");
    AST_LVL_WRITE: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_REG_LVL && req.wdata[3:0] <= LVL_MAX
        |=> st_r.lvl == $past(req.wdata[3:0]))
        else $error("regulator write not taken");
    AST_LVL_IGNORE: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_REG_LVL && req.wdata[3:0] > LVL_MAX
        |=> $stable(st_r.lvl))
        else $error("regulator took an illegal code");
    AST_LVL_BACK: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_REG_LVL
        |=> rdata[3:0] == $past(st_r.lvl))
        else $error("regulator readback wrong");
    // clock gating
    AST_NO_GATE: assert property (
        @(posedge clk) disable iff (reset)
        ce && !st_r.gate_sw
        |=> periph_clk_en == $past(st_r.run_en))
        else $error("clocks gated with switch clear");
    AST_GATE_WR: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_GATE_SW
        |=> st_r.gate_sw == $past(req.wdata[0]))
        else $error("gating switch write wrong");
    AST_GATE_READ: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_GATE_SW
        |=> rdata == {31'h0, $past(st_r.gate_sw)})
        else $error("gating switch readback wrong");
    AST_SLEEP_GATE: assert property (
        @(posedge clk) disable iff (reset)
        ce && st_r.gate_sw && cpu.sleep && !cpu.deep_sleep
        |=> periph_clk_en == $past(st_r.run_en & st_r.slp_en))
        else $error("sleep gating wrong");
    AST_DEEP_GATE: assert property (
        @(posedge clk) disable iff (reset)
        ce && st_r.gate_sw && cpu.deep_sleep
        |=> periph_clk_en == $past(st_r.run_en & st_r.dslp_en))
        else $error("deep-sleep gating wrong");
    AST_RUN_CLOCK: assert property (
        @(posedge clk) disable iff (reset)
        ce && !cpu.sleep && !cpu.deep_sleep
        |=> periph_clk_en == $past(st_r.run_en))
        else $error("run-mode clocks not restored");
    AST_CLK_NEEDS_RUN: assert property (
        @(posedge clk) disable iff (reset)
        ce
        |=> (periph_clk_en & ~$past(st_r.run_en)) == 33'h0)
        else $error("clock given to a disabled peripheral");
    AST_RUN_WR: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_RUN_EN
        |=> st_r.run_en[31:0] == $past(req.wdata))
        else $error("run enable write wrong");
    AST_DSLP_KEEP: assert property (
        @(posedge clk) disable iff (reset)
        ce && !(req.wr && (req.addr == A_DSLP_EN || req.addr == A_DSLP_EN_HI))
        |=> $stable(st_r.dslp_en))
        else $error("deep-sleep enables changed without a write");
    AST_DSLP_WR: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_DSLP_EN
        |=> st_r.dslp_en[31:0] == $past(req.wdata))
        else $error("deep-sleep enable write wrong");
    AST_DSLP_HI: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_DSLP_EN_HI
        |=> st_r.dslp_en[32] == $past(req.wdata[0]))
        else $error("deep-sleep top enable write wrong");
    AST_DSLP_READ: assert property (
        @(posedge clk) disable iff (reset)
        ce && req.rd && req.addr == A_DSLP_EN
        |=> rdata == $past(st_r.dslp_en[31:0]))
        else $error("deep-sleep enable readback wrong");
    // reset values, looked at on the first edge after release only
    AST_RESET_VAL: assert property (
        @(posedge clk)
        $past(reset) && !reset
        |-> st_r.lvl == LVL_RESET && st_r.int_en == 7'h0)
        else $error("reset values wrong");
    AST_RESET_GATE: assert property (
        @(posedge clk)
        $past(reset) && !reset
        |-> st_r.pend == 7'h0 && !st_r.gate_sw && st_r.run_en == RUN_RESET && st_r.dslp_en == DSLP_RESET)
        else $error("reset gating values wrong");
    // main scenarios
    CV_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(irq));
    CV_DEEP: cover property (@(posedge clk) disable iff (reset)
        st_r.gate_sw && cpu.deep_sleep && periph_clk_en != periph_run_en);
    CV_LVL: cover property (@(posedge clk) disable iff (reset) onchip_regulator == LVL_MAX);
    CV_SLEEP: cover property (@(posedge clk) disable iff (reset)
        st_r.gate_sw && cpu.sleep && periph_clk_en != periph_run_en);
    CV_CLR: cover property (@(posedge clk) disable iff (reset)
        ce && req.wr && req.addr == A_INT_CLR && st_r.pend != 7'h0);
endmodule : sgc_top
`default_nettype wire

// File: tb/sgc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// processor stand-in: state levels change only just after a clock edge
module sgc_cpu_model
    import sgc_pkg::*;
(
    // clock
    input wire logic clk,
    // commanded state: 0 run, 1 sleep, 2 deep-sleep
    input wire logic [1:0] mode,
    // state indications to the block
    output var sgc_pkg::sgc_cpu_t cpu
);
    always_ff @(posedge clk)
    begin
        cpu.sleep <= (mode == 2'h1);
        cpu.deep_sleep <= (mode == 2'h2);
    end
endmodule : sgc_cpu_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sgc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    sgc_req_t req = '0;
    logic [6:0] src_event = 7'h00;
    logic [1:0] mode = 2'h0;
    sgc_cpu_t cpu;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] onchip_regulator;
    logic [32:0] periph_clk_en;
    logic [32:0] periph_run_en;
    int bad_count = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    sgc_cpu_model cpu_m (.clk(clk), .mode(mode), .cpu(cpu));
    sgc_top dut (.clk(clk), .reset(reset), .ce(ce), .req(req), .rdata(rdata),
        .src_event(src_event), .cpu(cpu), .irq(irq), .onchip_regulator(onchip_regulator),
        .periph_clk_en(periph_clk_en), .periph_run_en(periph_run_en));
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so look mid-cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk({1'b0, rdata}, {1'b0, exp});
    endtask : rd
    task automatic cpu_state(input logic [1:0] m, input logic [32:0] exp);
        @(posedge clk);
        mode <= m;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(periph_clk_en, exp);
    endtask : cpu_state
    initial
    begin
        #40000;
        bad_count++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(periph_run_en, RUN_RESET);
        chk({29'h0, onchip_regulator}, {29'h0, LVL_RESET});
        rd(A_INT_EN, 32'h0);
        rd(A_INT_RAW, 32'h0);
        rd(A_GATE_SW, 32'h0);
        rd(A_DSLP_EN, 32'hFFFFFFFF);
        rd(A_DSLP_EN_HI, 32'h1);
        rd(A_REG_LVL, {28'h0, LVL_RESET});
        rd(A_RUN_EN, 32'h0);
        rd(8'h3C, 32'h0);
        wr(A_INT_EN_SET, 32'h05);
        wr(A_INT_EN_SET, 32'h40);
        rd(A_INT_EN, 32'h45);
        wr(A_INT_EN_CLR, 32'h04);
        rd(A_INT_EN, 32'h41);
        for (int i = 0; i < NSRC; i++)
        begin
            @(posedge clk);
            src_event[i] <= 1'b1;
            repeat (8) @(posedge clk);
            rd(A_INT_RAW, (32'h2 << i) - 32'h1);
        end
        chk({32'h0, irq}, 33'h1);
        rd(A_INT_MSK, 32'h41);
        @(posedge clk);
        src_event <= 7'h00;
        wr(A_INT_CLR, 32'h41);
        repeat (2) @(negedge clk);
        chk({32'h0, irq}, 33'h0);
        rd(A_INT_RAW, 32'h3E);
        rd(A_INT_MSK, 32'h0);
        wr(A_INT_EN_SET, 32'h02);
        rd(A_INT_MSK, 32'h02);
        chk({32'h0, irq}, 33'h1);
        for (int c = 0; c <= int'(LVL_MAX); c++)
        begin
            wr(A_REG_LVL, 32'(c));
            rd(A_REG_LVL, 32'(c));
            chk({29'h0, onchip_regulator}, 33'(c));
        end
        // a code past the top level must leave the setting alone
        wr(A_REG_LVL, 32'hB);
        rd(A_REG_LVL, 32'hA);
        wr(A_RUN_EN, 32'h000000F0);
        wr(A_RUN_EN_HI, 32'h1);
        wr(A_SLP_EN, 32'h000000C0);
        wr(A_DSLP_EN, 32'h00000030);
        wr(A_DSLP_EN_HI, 32'h0);
        @(negedge clk);
        chk(periph_run_en, 33'h1000000F0);
        cpu_state(2'h0, 33'h1000000F0);
        cpu_state(2'h2, 33'h1000000F0);
        cpu_state(2'h1, 33'h1000000F0);
        cpu_state(2'h0, 33'h1000000F0);
        wr(A_GATE_SW, 32'h1);
        cpu_state(2'h1, 33'h1000000C0);
        cpu_state(2'h2, 33'h000000030);
        cpu_state(2'h0, 33'h1000000F0);
        rd(A_DSLP_EN, 32'h30);
        wr(A_INT_EN, 32'h08);
        rd(A_INT_MSK, 32'h08);
        wr(A_INT_EN, 32'h00);
        @(negedge clk);
        chk({32'h0, irq}, 33'h0);
        // with the clock enable low a write must leave the regulator setting alone
        @(posedge clk);
        ce <= 1'b0;
        wr(A_REG_LVL, 32'h3);
        @(negedge clk);
        chk({29'h0, onchip_regulator}, 33'hA);
        @(posedge clk);
        ce <= 1'b1;
        rd(A_REG_LVL, 32'hA);
        summarize();
    end
endmodule : tb
`default_nettype wire
